// ==== common/csb_pkg.sv ====
// Shared constants and types for the compare, skip and branch unit
package csb_pkg;

    // Widths
    localparam int PC_W   = 16;
    localparam int OFFS_W = 7;
    localparam int ADDR_W = 12;

    // Register byte offsets on the APB
    localparam logic [ADDR_W-1:0] REG_FLAGS = 12'h000;
    localparam logic [ADDR_W-1:0] REG_PC    = 12'h004;
    localparam logic [ADDR_W-1:0] REG_STAT  = 12'h008;

    // Values after reset
    localparam logic [7:0]      FLAGS_RST = 8'h00;
    localparam logic [PC_W-1:0] PC_RST    = 16'h0000;

    // Flag positions in status_flags_register
    localparam int FLG_C = 0;
    localparam int FLG_Z = 1;
    localparam int FLG_N = 2;
    localparam int FLG_V = 3;
    localparam int FLG_H = 5;

    // Status register fields
    localparam int STAT_BUSY  = 0;
    localparam int STAT_TAKEN = 1;

    // Program counter steps
    localparam logic [PC_W-1:0] PC_STEP_ONE   = 16'h0001;
    localparam logic [PC_W-1:0] PC_STEP_SKIP1 = 16'h0002;
    localparam logic [PC_W-1:0] PC_STEP_SKIP2 = 16'h0003;

    typedef enum logic [3:0] {
        OP_NOP                 = 4'h0,
        OP_COMPARE_REGS        = 4'h1,
        OP_COMPARE_WITH_BORROW = 4'h2,
        OP_COMPARE_IMMEDIATE   = 4'h3,
        OP_SKIP_REG_BIT_CLEAR  = 4'h4,
        OP_SKIP_REG_BIT_SET    = 4'h5,
        OP_SKIP_IO_BIT_CLEAR   = 4'h6,
        OP_SKIP_IO_BIT_SET     = 4'h7,
        OP_BRANCH_FLAG_SET     = 4'h8,
        OP_BRANCH_FLAG_CLEAR   = 4'h9,
        OP_BRANCH_ON_EQUAL     = 4'hA,
        OP_BRANCH_ON_NOT_EQUAL = 4'hB
    } csb_op_t;

    typedef enum logic [1:0] {
        ST_IDLE  = 2'h0,
        ST_LAST  = 2'h1,
        ST_EXTRA = 2'h3
    } csb_state_t;

    typedef struct packed {
        csb_op_t           op;
        logic [7:0]        rd_val;
        logic [7:0]        rr_val;
        logic [7:0]        imm;
        logic [2:0]        bit_sel;
        logic [OFFS_W-1:0] offs;
        logic [7:0]        io_val;
        logic              next_two_word;
    } csb_instr_t;

    typedef struct packed {
        logic h;
        logic v;
        logic n;
        logic z;
        logic c;
    } csb_cmp_flags_t;

endpackage

// ==== core/csb_cmp_alu.sv ====
// Subtract-without-store flag generator for the compare instructions
`timescale 1ns/1ps
module csb_cmp_alu
(
    // Operands
    input  wire logic                    a,
    input  wire logic [7:0]              minuend,
    input  wire logic [7:0]              subtrahend,
    input  wire logic                    borrow_in,
    input  wire logic                    zero_in,
    // Result flags
    output      csb_pkg::csb_cmp_flags_t flags
);
    import csb_pkg::*;

    logic [8:0] diff;
    logic [7:0] r;

    always_comb
    begin
        diff = {1'b0, minuend} - {1'b0, subtrahend} - {8'h00, a & borrow_in};
        r    = diff[7:0];
        flags.c = diff[8];
        // Borrow form keeps zero only if it was already set
        flags.z = (r == 8'h00) && (!a || zero_in);
        flags.n = r[7];
        flags.v = (minuend[7] & ~subtrahend[7] & ~r[7]) | (~minuend[7] & subtrahend[7] & r[7]);
        flags.h = (~minuend[3] & subtrahend[3]) | (subtrahend[3] & r[3]) | (r[3] & ~minuend[3]);
    end

endmodule // csb_cmp_alu

// ==== core/csb_apb_regs.sv ====
// APB slave: decode, write strobes and registered read data
`timescale 1ns/1ps
module csb_apb_regs
(
    // Clock and reset
    input  wire logic                         pclk,
    input  wire logic                         presetn,
    // APB
    input  wire logic                         psel,
    input  wire logic                         penable,
    input  wire logic                         pwrite,
    input  wire logic [csb_pkg::ADDR_W-1:0]   paddr,
    input  wire logic [31:0]                  pwdata,
    output      logic                         pready,
    output      logic                         pslverr,
    output      logic [31:0]                  prdata,
    // Register file side
    input  wire logic [7:0]                   flags_val,
    input  wire logic [csb_pkg::PC_W-1:0]     pc_val,
    input  wire logic [1:0]                   stat_val,
    output      logic                         flags_we,
    output      logic                         pc_we
);
    import csb_pkg::*;

    logic hit;
    logic commit;
    logic [31:0] rdata_d;

    assign hit     = (paddr == REG_FLAGS) || (paddr == REG_PC) || (paddr == REG_STAT);
    assign pready  = 1'b1;
    assign commit  = psel && penable;
    assign pslverr = commit && !hit;
    assign flags_we = commit && pwrite && (paddr == REG_FLAGS);
    assign pc_we    = commit && pwrite && (paddr == REG_PC);

    always_comb
    begin
        rdata_d = 32'h0000_0000;
        if (paddr == REG_FLAGS)
            rdata_d = {24'h00_0000, flags_val};
        else if (paddr == REG_PC)
            rdata_d = {16'h0000, pc_val};
        else if (paddr == REG_STAT)
            rdata_d = {30'h0000_0000, stat_val};
    end

    // Read data captured in the setup cycle
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            prdata <= 32'h0000_0000;
        else if (psel && !penable)
            prdata <= pwrite ? 32'h0000_0000 : rdata_d;
    end

endmodule // csb_apb_regs

// ==== core/csb_core.sv ====
// Compare, bit-test skip and conditional branch execution unit
//
// Functional notes
// - Compares subtract without storing, update Z, N, V, C and H, and finish in one cycle.
// - Skip-on-register-bit-clear advances the PC by 2 or 3 when the bit is 0, flags untouched.
// - Skip-on-register-bit-set advances the PC by 2 or 3 when the bit is 1, flags untouched.
// - Skip-on-I/O-bit-clear advances the PC by 2 or 3 when the I/O bit reads 0, flags untouched.
// - Skip-on-I/O-bit-set advances the PC by 2 or 3 when the I/O bit reads 1, flags untouched.
// - Branch-on-flag-set loads PC + k + 1 when the selected flag is 1, flags untouched.
// - Branch-on-flag-clear loads PC + k + 1 when the selected flag is 0, flags untouched.
// - Branch-on-equal jumps to PC + k + 1 only when Z is 1, flags untouched.
// - Branch-on-not-equal jumps to PC + k + 1 only when Z is 0, flags untouched.
//
// Local design decisions: the APB register port and the placing of the registers.
`timescale 1ns/1ps
module csb_core
(
    // Clock and reset
    input  wire logic                       pclk,
    input  wire logic                       presetn,
    // APB register port
    input  wire logic                       psel,
    input  wire logic                       penable,
    input  wire logic                       pwrite,
    input  wire logic [csb_pkg::ADDR_W-1:0] paddr,
    input  wire logic [31:0]                pwdata,
    output      logic                       pready,
    output      logic                       pslverr,
    output      logic [31:0]                prdata,
    // Instruction issue
    input  wire csb_pkg::csb_instr_t        instr,
    input  wire logic                       instr_valid,
    output      logic                       instr_ready,
    output      logic                       retire,
    // Architectural state
    output      logic [csb_pkg::PC_W-1:0]   pc,
    output      logic [7:0]                 flags
);
    import csb_pkg::*;

    csb_state_t      state_q;
    csb_state_t      state_d;
    logic [PC_W-1:0] pc_q;
    logic [PC_W-1:0] pc_d;
    logic [7:0]      flags_q;
    logic            retire_q;
    logic            taken_q;
    logic            acc;
    logic            is_cmp;
    logic            is_skip;
    logic            is_branch;
    logic            cond;
    logic [PC_W-1:0] pc_inc;
    logic [PC_W-1:0] rel;
    logic            flags_we;
    logic            pc_we;
    logic [7:0]      cmp_b;
    csb_cmp_flags_t  cmp_f;

    assign instr_ready = (state_q == ST_IDLE);
    assign acc         = instr_valid && instr_ready;
    assign pc          = pc_q;
    assign flags       = flags_q;
    assign retire      = retire_q;

    assign is_cmp    = (instr.op == OP_COMPARE_REGS) || (instr.op == OP_COMPARE_WITH_BORROW)
                    || (instr.op == OP_COMPARE_IMMEDIATE);
    assign is_skip   = (instr.op >= OP_SKIP_REG_BIT_CLEAR) && (instr.op <= OP_SKIP_IO_BIT_SET);
    assign is_branch = (instr.op >= OP_BRANCH_FLAG_SET) && (instr.op <= OP_BRANCH_ON_NOT_EQUAL);

    // Immediate form takes K in place of the second register
    assign cmp_b = (instr.op == OP_COMPARE_IMMEDIATE) ? instr.imm : instr.rr_val;

    csb_cmp_alu u_alu
    (
        .a          (instr.op == OP_COMPARE_WITH_BORROW),
        .minuend    (instr.rd_val),
        .subtrahend (cmp_b),
        .borrow_in  (flags_q[FLG_C]),
        .zero_in    (flags_q[FLG_Z]),
        .flags      (cmp_f)
    );

    csb_apb_regs u_regs
    (
        .pclk      (pclk),
        .presetn   (presetn),
        .psel      (psel),
        .penable   (penable),
        .pwrite    (pwrite),
        .paddr     (paddr),
        .pwdata    (pwdata),
        .pready    (pready),
        .pslverr   (pslverr),
        .prdata    (prdata),
        .flags_val (flags_q),
        .pc_val    (pc_q),
        .stat_val  ({taken_q, !instr_ready}),
        .flags_we  (flags_we),
        .pc_we     (pc_we)
    );

    // Condition of the skip or branch
    always_comb
    begin
        cond = 1'b0;
        case (instr.op)
            OP_SKIP_REG_BIT_CLEAR:  cond = !instr.rr_val[instr.bit_sel];
            OP_SKIP_REG_BIT_SET:    cond = instr.rr_val[instr.bit_sel];
            OP_SKIP_IO_BIT_CLEAR:   cond = !instr.io_val[instr.bit_sel];
            OP_SKIP_IO_BIT_SET:     cond = instr.io_val[instr.bit_sel];
            OP_BRANCH_FLAG_SET:     cond = flags_q[instr.bit_sel];
            OP_BRANCH_FLAG_CLEAR:   cond = !flags_q[instr.bit_sel];
            OP_BRANCH_ON_EQUAL:     cond = flags_q[FLG_Z];
            OP_BRANCH_ON_NOT_EQUAL: cond = !flags_q[FLG_Z];
            default:                cond = 1'b0;
        endcase
    end

    assign pc_inc = pc_q + PC_STEP_ONE;
    assign rel    = {{(PC_W-OFFS_W){instr.offs[OFFS_W-1]}}, instr.offs};

    always_comb
    begin
        pc_d = pc_q;
        if (acc && instr.op != OP_NOP)
        begin
            if (cond && is_branch)
                pc_d = pc_inc + rel;
            else if (cond && is_skip)
                pc_d = pc_q + (instr.next_two_word ? PC_STEP_SKIP2 : PC_STEP_SKIP1);
            else
                pc_d = pc_inc;
        end
    end

    // Stall states for taken skips and branches
    always_comb
    begin
        state_d = state_q;
        unique case (state_q)
            ST_IDLE:
                if (acc && cond && is_skip && instr.next_two_word)
                    state_d = ST_EXTRA;
                else if (acc && cond && (is_skip || is_branch))
                    state_d = ST_LAST;
            ST_EXTRA:
                state_d = ST_LAST;
            ST_LAST:
                state_d = ST_IDLE;
            default:
                state_d = ST_IDLE;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            state_q <= ST_IDLE;
        else
            state_q <= state_d;
    end

    // Program counter; an issued instruction wins over a bus write
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            pc_q <= PC_RST;
        else if (acc)
            pc_q <= pc_d;
        else if (pc_we)
            pc_q <= pwdata[PC_W-1:0];
    end

    // Flags change only for compares, or for a bus write in a cycle with no instruction issued
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            flags_q <= FLAGS_RST;
        else if (acc && is_cmp)
        begin
            flags_q[FLG_C] <= cmp_f.c;
            flags_q[FLG_Z] <= cmp_f.z;
            flags_q[FLG_N] <= cmp_f.n;
            flags_q[FLG_V] <= cmp_f.v;
            flags_q[FLG_H] <= cmp_f.h;
        end
        else if (flags_we && !acc)
            flags_q <= pwdata[7:0];
    end

    // Completion pulse and last-taken status
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            retire_q <= 1'b0;
            taken_q  <= 1'b0;
        end
        else
        begin
            retire_q <= (acc && !(cond && (is_skip || is_branch))) || (state_q == ST_LAST);
            if (acc && (is_skip || is_branch))
                taken_q <= cond;
        end
    end

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    AST_CMP_ONE_CYCLE: assert property (acc && is_cmp |=> instr_ready && pc_q == $past(pc_q) + 16'h0001)
        else $error("compare did not finish in one cycle");

    AST_CMP_EQUAL_Z: assert property (acc && instr.op == OP_COMPARE_REGS
        && instr.rd_val == instr.rr_val |=> flags_q[FLG_Z] && !flags_q[FLG_C])
        else $error("equal compare gave wrong Z or C");

    // Borrow form may clear Z but never set it
    AST_CMP_BORROW_Z: assert property (acc && instr.op == OP_COMPARE_WITH_BORROW
        && !flags_q[FLG_Z] |=> !flags_q[FLG_Z])
        else $error("borrow compare set Z");

    AST_SKIP_REG_CLR: assert property (acc && instr.op == OP_SKIP_REG_BIT_CLEAR
        && !instr.rr_val[instr.bit_sel] && !instr.next_two_word
        |=> pc_q == $past(pc_q) + 16'h0002 && flags_q == $past(flags_q))
        else $error("register bit clear skip wrong");

    AST_SKIP_REG_CLR_TWO: assert property (acc && instr.op == OP_SKIP_REG_BIT_CLEAR
        && !instr.rr_val[instr.bit_sel] && instr.next_two_word
        |=> pc_q == $past(pc_q) + 16'h0003 ##1 !instr_ready ##1 instr_ready && retire)
        else $error("two-word register bit clear skip wrong");

    AST_SKIP_REG_SET: assert property (acc && instr.op == OP_SKIP_REG_BIT_SET
        && instr.rr_val[instr.bit_sel] && instr.next_two_word
        |=> pc_q == $past(pc_q) + 16'h0003 ##1 !instr_ready ##1 instr_ready)
        else $error("register bit set skip wrong");

    AST_SKIP_REG_SET_NOT: assert property (acc && instr.op == OP_SKIP_REG_BIT_SET
        && !instr.rr_val[instr.bit_sel] |=> pc_q == $past(pc_q) + 16'h0001 && instr_ready)
        else $error("register bit set skip taken on a clear bit");

    AST_SKIP_IO_CLR: assert property (acc && instr.op == OP_SKIP_IO_BIT_CLEAR
        && instr.io_val[instr.bit_sel] |=> pc_q == $past(pc_q) + 16'h0001 && instr_ready)
        else $error("I/O bit clear skip taken on a set bit");

    AST_SKIP_IO_CLR_TAKEN: assert property (acc && instr.op == OP_SKIP_IO_BIT_CLEAR
        && !instr.io_val[instr.bit_sel] && !instr.next_two_word
        |=> pc_q == $past(pc_q) + 16'h0002 ##1 instr_ready)
        else $error("I/O bit clear skip not taken on a clear bit");

    AST_SKIP_IO_SET: assert property (acc && instr.op == OP_SKIP_IO_BIT_SET
        && instr.io_val[instr.bit_sel] && !instr.next_two_word
        |=> pc_q == $past(pc_q) + 16'h0002 ##1 instr_ready)
        else $error("I/O bit set skip wrong");

    AST_BR_FLAG_SET: assert property (acc && instr.op == OP_BRANCH_FLAG_SET
        && flags_q[instr.bit_sel]
        |=> pc_q == $past(pc_q) + 16'h0001 + {{9{$past(instr.offs[6])}}, $past(instr.offs)})
        else $error("flag set branch target wrong");

    AST_BR_FLAG_SET_NOT: assert property (acc && instr.op == OP_BRANCH_FLAG_SET
        && !flags_q[instr.bit_sel] |=> pc_q == $past(pc_q) + 16'h0001 && instr_ready)
        else $error("flag set branch taken on a clear flag");

    AST_BR_FLAG_CLR: assert property (acc && instr.op == OP_BRANCH_FLAG_CLEAR
        && flags_q[instr.bit_sel] |=> pc_q == $past(pc_q) + 16'h0001 && instr_ready)
        else $error("flag clear branch taken on a set flag");

    AST_BR_FLAG_CLR_TAKEN: assert property (acc && instr.op == OP_BRANCH_FLAG_CLEAR
        && !flags_q[instr.bit_sel]
        |=> pc_q == $past(pc_q) + 16'h0001 + {{9{$past(instr.offs[6])}}, $past(instr.offs)})
        else $error("flag clear branch target wrong");

    AST_BR_EQUAL: assert property (acc && instr.op == OP_BRANCH_ON_EQUAL && flags_q[FLG_Z]
        |=> !instr_ready && flags_q == $past(flags_q) ##1 instr_ready && retire)
        else $error("equal branch timing or flags wrong");

    AST_BR_NOT_EQUAL: assert property (acc && instr.op == OP_BRANCH_ON_NOT_EQUAL
        && flags_q[FLG_Z] |=> pc_q == $past(pc_q) + 16'h0001 && flags_q == $past(flags_q))
        else $error("not-equal branch taken with Z set");

    AST_BR_NOT_EQUAL_TAKEN: assert property (acc && instr.op == OP_BRANCH_ON_NOT_EQUAL
        && !flags_q[FLG_Z]
        |=> pc_q == $past(pc_q) + 16'h0001 + {{9{$past(instr.offs[6])}}, $past(instr.offs)})
        else $error("not-equal branch target wrong");

    AST_FALSE_ONE_CYCLE: assert property (acc && (is_skip || is_branch) && !cond |=> instr_ready && retire)
        else $error("false condition cost more than one cycle");

    AST_FLAGS_KEPT: assert property (acc
        && (is_skip || is_branch) |=> flags_q == $past(flags_q))
        else $error("skip or branch changed the flags");

    // Distance measured modulo the PC width, so wrapping targets still hold
    AST_BACKWARD_BRANCH: assert property (acc && is_branch && cond && instr.offs[6]
        |=> (16'($past(pc_q) + 16'h0001 - pc_q) != 16'h0000)
        && (16'($past(pc_q) + 16'h0001 - pc_q) <= 16'h0040))
        else $error("negative offset did not branch backward");

    AST_FORWARD_BRANCH: assert property (acc && is_branch && cond && !instr.offs[6]
        |=> (16'(pc_q - $past(pc_q)) != 16'h0000) && (16'(pc_q - $past(pc_q)) <= 16'h0040))
        else $error("positive offset did not branch forward");

    COV_CMP: cover property (acc && instr.op == OP_COMPARE_WITH_BORROW);
    COV_SKIP_TWO_WORD: cover property (acc && is_skip && cond && instr.next_two_word);
    COV_BR_TAKEN: cover property (acc && is_branch && cond);
    COV_BR_BACKWARD: cover property (acc && is_branch && cond && instr.offs[6]);
    COV_APB_PC_WRITE: cover property (pc_we && !acc);

endmodule // csb_core

// ==== bench/test_csb_core.sv ====
// Self-checking bench for the compare, skip and branch unit
`timescale 1ns/1ps
module test_csb_core;
    import csb_pkg::*;

    logic              pclk;
    logic              presetn;
    logic              psel;
    logic              penable;
    logic              pwrite;
    logic [ADDR_W-1:0] paddr;
    logic [31:0]       pwdata;
    logic              pready;
    logic              pslverr;
    logic [31:0]       prdata;
    csb_instr_t        instr;
    logic              instr_valid;
    logic              instr_ready;
    logic              retire;
    logic [PC_W-1:0]   pc;
    logic [7:0]        flags;
    int                n_fail;
    int                n_checks;
    int                seed;
    int                m_pc;
    int                m_fl;
    int                m_tk;
    logic [31:0]       rd;
    logic [31:0]       rv;
    logic              er;

    csb_core dut
    (
        .pclk        (pclk),
        .presetn     (presetn),
        .psel        (psel),
        .penable     (penable),
        .pwrite      (pwrite),
        .paddr       (paddr),
        .pwdata      (pwdata),
        .pready      (pready),
        .pslverr     (pslverr),
        .prdata      (prdata),
        .instr       (instr),
        .instr_valid (instr_valid),
        .instr_ready (instr_ready),
        .retire      (retire),
        .pc          (pc),
        .flags       (flags)
    );

    always #10 pclk = ~pclk;

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    // One APB transfer; request held until pready is seen at an edge
    task automatic apb(input logic w, input logic [ADDR_W-1:0] a, input logic [31:0] d,
                       output logic [31:0] q, output logic e);
        int n;
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do
        begin
            @(posedge pclk);
            n++;
        end
        while (pready !== 1'b1 && n < 50);
        check({31'h0000_0000, pready}, 32'h0000_0001);
        q = prdata;
        e = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    // Reference behaviour, then issue and compare pc, flags and cycles
    task automatic run(input csb_instr_t i);
        int a, b, ci, full, r, sa, sb, cond, cyc, epc, efl, n, k;
        a = i.rd_val;
        b = (i.op == OP_COMPARE_IMMEDIATE) ? i.imm : i.rr_val;
        ci = (i.op == OP_COMPARE_WITH_BORROW) ? m_fl[FLG_C] : 0;
        k = i.offs[6] ? int'(i.offs) - 128 : int'(i.offs);
        epc = (m_pc + 1) & 16'hFFFF;
        efl = m_fl;
        cyc = 1;
        cond = 0;
        case (i.op)
            OP_SKIP_REG_BIT_CLEAR:  cond = !i.rr_val[i.bit_sel];
            OP_SKIP_REG_BIT_SET:    cond = i.rr_val[i.bit_sel];
            OP_SKIP_IO_BIT_CLEAR:   cond = !i.io_val[i.bit_sel];
            OP_SKIP_IO_BIT_SET:     cond = i.io_val[i.bit_sel];
            OP_BRANCH_FLAG_SET:     cond = m_fl[i.bit_sel];
            OP_BRANCH_FLAG_CLEAR:   cond = !m_fl[i.bit_sel];
            OP_BRANCH_ON_EQUAL:     cond = m_fl[FLG_Z];
            OP_BRANCH_ON_NOT_EQUAL: cond = !m_fl[FLG_Z];
            default:
            begin
                full = a - b - ci;
                r = full & 255;
                sa = a > 127 ? a - 256 : a;
                sb = b > 127 ? b - 256 : b;
                efl = m_fl & 8'hD0;
                efl[FLG_C] = full < 0;
                efl[FLG_Z] = (r == 0) && (i.op != OP_COMPARE_WITH_BORROW || m_fl[FLG_Z]);
                efl[FLG_N] = r[7];
                efl[FLG_V] = (sa - sb - ci > 127) || (sa - sb - ci < -128);
                efl[FLG_H] = ((a & 15) - (b & 15) - ci) < 0;
            end
        endcase
        if (cond && i.op >= OP_BRANCH_FLAG_SET)
        begin
            epc = (m_pc + k + 1) & 16'hFFFF;
            cyc = 2;
        end
        else if (cond)
        begin
            epc = (m_pc + (i.next_two_word ? 3 : 2)) & 16'hFFFF;
            cyc = i.next_two_word ? 3 : 2;
        end
        @(posedge pclk);
        instr       <= i;
        instr_valid <= 1'b1;
        @(posedge pclk);
        instr_valid <= 1'b0;
        n = 1;
        #1;
        while (retire !== 1'b1 && n < 20)
        begin
            @(posedge pclk);
            #1;
            n++;
        end
        check(n, cyc);
        check(pc, epc);
        check(flags, efl);
        check(instr_ready, 1'b1);
        m_pc = epc;
        m_fl = efl;
        if (i.op >= OP_SKIP_REG_BIT_CLEAR)
            m_tk = cond;
    endtask

    function automatic csb_instr_t rnd(input csb_op_t op);
        csb_instr_t i;
        logic [63:0] raw;
        raw = {$random(seed), $random(seed)};
        i = raw[$bits(csb_instr_t)-1:0];
        i.op = op;
        return i;
    endfunction

    initial
    begin
        #(20 * 20000);
        n_fail++;
        report_and_stop();
    end

    initial
    begin
        csb_instr_t i;
        pclk = 1'b0;
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = '0;
        pwdata = '0;
        instr = '0;
        instr_valid = 1'b0;
        n_fail = 0;
        n_checks = 0;
        seed = 22;
        m_pc = 0;
        m_fl = 0;
        m_tk = 0;
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        // Reset values and register access
        check(pc, PC_RST);
        check(flags, FLAGS_RST);
        apb(1'b0, REG_STAT, 32'h0000_0000, rd, er);
        check(rd, 32'h0000_0000);
        apb(1'b1, REG_STAT, 32'hFFFF_FFFF, rd, er);
        apb(1'b0, REG_STAT, 32'h0000_0000, rd, er);
        check(rd, 32'h0000_0000);
        apb(1'b0, 12'h0FC, 32'h0000_0000, rd, er);
        check(rd, 32'h0000_0000);
        check({31'h0000_0000, er}, 32'h0000_0001);
        apb(1'b1, REG_PC, 32'h0000_FFF0, rd, er);
        apb(1'b0, REG_PC, 32'h0000_0000, rd, er);
        check(rd, 32'h0000_FFF0);
        m_pc = 16'hFFF0;
        $display("test registers done");
        // Compares with equal and random operands
        for (int t = 0; t < 60; t++)
        begin
            i = rnd(csb_op_t'(OP_COMPARE_REGS + t % 3));
            if (t % 5 == 0)
                i.rr_val = i.rd_val;
            if (t % 5 == 0)
                i.imm = i.rd_val;
            run(i);
        end
        $display("test compares done");
        // Skips and branches under random flags and pc
        for (int t = 0; t < 160; t++)
        begin
            if (t % 4 == 0)
            begin
                rv = $random(seed);
                apb(1'b1, REG_FLAGS, {24'h00_0000, rv[7:0]}, rd, er);
                m_fl = rv[7:0];
                apb(1'b0, REG_FLAGS, 32'h0000_0000, rd, er);
                check(rd, m_fl);
            end
            i = rnd(csb_op_t'(OP_SKIP_REG_BIT_CLEAR + t % 8));
            run(i);
            apb(1'b0, REG_STAT, 32'h0000_0000, rd, er);
            check(rd[1:0], {m_tk[0], 1'b0});
        end
        $display("test skips and branches done");
        report_and_stop();
    end
endmodule // test_csb_core
